// >>> hw/bus_exerciser.sv
// target bus exerciser with single-step and trace-capture control
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module bus_exerciser #(
    parameter int ADDR_W = exer_pkg::ADDR_W,
    parameter int DATA_W = exer_pkg::DATA_W
) (
    // clock, reset, enable
    input  wire logic              clk_sys,
    input  wire logic              reset,
    input  wire logic              clk_en,
    // avalon-mm slave
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // operator character channel
    input  wire logic              op_char_valid,
    input  wire logic [7:0]        op_char,
    // target bus master side
    output logic                   tgt_req,
    output logic                   tgt_wr,
    output logic                   tgt_io,
    output logic      [2:0]        tgt_status,
    output logic      [ADDR_W-1:0] tgt_addr,
    output logic      [DATA_W-1:0] tgt_wdata,
    output logic                   tgt_byte,
    input  wire logic              tgt_ack,
    input  wire logic [DATA_W-1:0] tgt_rdata,
    // processor run control
    input  wire logic              tgt_irq,
    input  wire logic              tgt_instr_done,
    input  wire logic [31:0]       tgt_cs_ip,
    input  wire logic [3:0]        evt_group,
    input  wire logic              evt_hit,
    output logic                   cpu_run,
    output logic                   irq_accept,
    output logic                   irq_flag,
    // trace and event monitor
    output logic                   trace_acquire,
    output logic                   evt_enable,
    output logic                   evt_action
);
    localparam logic [DATA_W-1:0] ONE = {{(DATA_W-1){1'b0}}, 1'b1};

    // software registers
    logic              sti_r, tce_r, byte_r, io_r;
    logic [2:0]        mss_r;
    logic [7:0]        rst_char_r;
    logic [ADDR_W-1:0] first_r, last_r;
    logic [DATA_W-1:0] data_r, rd_last_r;
    logic              refused_r;
    logic [31:0]       cs_ip_r;
    logic [3:0]        group_r;
    // exerciser state
    exer_pkg::fn_t     fn_r;
    exer_pkg::bus_st_t st_r;
    logic              phase_r;
    logic [ADDR_W-1:0] cur_r;
    logic [DATA_W-1:0] pat_r;
    // step control
    logic              paused_r, stepping_r;

    logic [1:0] idx;
    logic       wr_go, rd_go, stop_hit, ctrl_wr, step_wr;
    assign idx      = avs_address[3:2];
    // writes land on the edge where the master sees waitrequest low
    assign wr_go    = clk_en && avs_write && !avs_waitrequest;
    assign rd_go    = clk_en && avs_read && avs_waitrequest;
    assign ctrl_wr  = wr_go && idx == exer_pkg::IDX_CTRL;
    assign step_wr  = ctrl_wr && avs_writedata[12];
    assign stop_hit = clk_en && op_char_valid && op_char == rst_char_r;

    // one wait cycle per access: waitrequest drops on the second cycle
    always_ff @(posedge clk_sys) begin
        if (reset)
            avs_waitrequest <= 1'b1;
        else if (clk_en)
            avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sti_r      <= exer_pkg::CTRL_RST[exer_pkg::CTL_STI];
            tce_r      <= exer_pkg::CTRL_RST[exer_pkg::CTL_TCE];
            byte_r     <= exer_pkg::CTRL_RST[exer_pkg::CTL_BYTE];
            io_r       <= exer_pkg::CTRL_RST[exer_pkg::CTL_IO];
            mss_r      <= exer_pkg::MSS_RST;
            rst_char_r <= exer_pkg::RESET_CHAR_RST;
            first_r    <= '0;
            last_r     <= '0;
            data_r     <= '0;
        end else if (wr_go) begin
            unique case (idx)
                exer_pkg::IDX_CTRL: begin
                    sti_r   <= avs_writedata[exer_pkg::CTL_STI];
                    tce_r   <= avs_writedata[exer_pkg::CTL_TCE];
                    mss_r   <= avs_writedata[exer_pkg::CTL_SS_LO +: 3];
                    if (paused_r && fn_r == exer_pkg::FN_NONE) begin
                        byte_r <= avs_writedata[exer_pkg::CTL_BYTE];
                        io_r   <= avs_writedata[exer_pkg::CTL_IO];
                    end
                    rst_char_r <= avs_writedata[23:16];
                end
                exer_pkg::IDX_ADDR: first_r <= avs_writedata[ADDR_W-1:0];
                exer_pkg::IDX_LAST: last_r  <= avs_writedata[ADDR_W-1:0];
                exer_pkg::IDX_DATA: data_r  <= avs_writedata[DATA_W-1:0];
            endcase
        end
    end

    // read mux: status shows paused, running function, refusal; data word shows last read
    always_ff @(posedge clk_sys) begin
        if (reset)
            avs_readdata <= '0;
        else if (rd_go) begin
            unique case (idx)
                exer_pkg::IDX_STAT: avs_readdata <= {refused_r, 7'h0,
                    group_r, rst_char_r, 1'b0, mss_r, 1'b0, fn_r,
                    io_r, byte_r, tce_r, sti_r} | {24'h0, paused_r, 7'h0};
                exer_pkg::IDX_ADDR: avs_readdata <= cs_ip_r;
                exer_pkg::IDX_LAST: avs_readdata <= 32'(last_r);
                exer_pkg::IDX_DATA: avs_readdata <= 32'(rd_last_r);
            endcase
        end
    end

    // function start: refused while running
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fn_r      <= exer_pkg::FN_NONE;
            refused_r <= 1'b0;
        end else if (stop_hit)
            fn_r <= exer_pkg::FN_NONE;
        else if (ctrl_wr && avs_writedata[exer_pkg::CTL_FN_LO +: 3] != 3'h0)
        begin
            if (paused_r && fn_r == exer_pkg::FN_NONE) begin
                fn_r <= exer_pkg::fn_t'(avs_writedata[exer_pkg::CTL_FN_LO +: 3]);
                refused_r <= 1'b0;
            end else
                refused_r <= 1'b1;
        end
    end

    function automatic logic [DATA_W-1:0] rotl(input logic [DATA_W-1:0] v,
                                              input logic b);
        logic [DATA_W-1:0] r;
        r = {v[DATA_W-2:0], v[DATA_W-1]};
        if (b)
            r = {{(DATA_W-8){1'b0}}, v[6:0], v[7]};
        return r;
    endfunction : rotl

    // target bus sequencer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_r       <= exer_pkg::ST_IDLE;
            phase_r    <= 1'b0;
            cur_r      <= '0;
            pat_r      <= '0;
            rd_last_r  <= '0;
            tgt_req    <= 1'b0;
            tgt_wr     <= 1'b0;
            tgt_io     <= 1'b0;
            tgt_status <= exer_pkg::MSS_RST;
            tgt_addr   <= '0;
            tgt_wdata  <= '0;
            tgt_byte   <= 1'b0;
        end else if (clk_en) begin
            unique case (st_r)
                exer_pkg::ST_IDLE: begin
                    phase_r <= 1'b0;
                    cur_r   <= first_r;
                    pat_r   <= (fn_r == exer_pkg::FN_INCR) ? '0 : data_r;
                    if (fn_r != exer_pkg::FN_NONE && !stop_hit)
                        st_r <= exer_pkg::ST_ISSUE;
                end
                exer_pkg::ST_ISSUE: begin
                    tgt_req  <= 1'b1;
                    tgt_addr <= cur_r;
                    tgt_byte <= byte_r;
                    tgt_io   <= io_r;
                    tgt_status <= io_r ? exer_pkg::IOS_STATUS : mss_r;
                    tgt_wdata <= pat_r;
                    unique case (fn_r)
                        exer_pkg::FN_WRRD:  tgt_wr <= !phase_r;
                        exer_pkg::FN_RANGE: tgt_wr <= 1'b0;
                        default:            tgt_wr <= 1'b1;
                    endcase
                    st_r <= exer_pkg::ST_WAIT;
                end
                exer_pkg::ST_WAIT: begin
                    if (tgt_ack) begin
                        tgt_req <= 1'b0;
                        if (!tgt_wr)
                            rd_last_r <= tgt_rdata;
                        unique case (fn_r)
                            exer_pkg::FN_ROTATE: pat_r <= rotl(pat_r, byte_r);
                            exer_pkg::FN_INCR:   pat_r <= pat_r + ONE;
                            exer_pkg::FN_WRRD:   phase_r <= !phase_r;
                            exer_pkg::FN_RANGE:
                                cur_r <= (cur_r == last_r) ? first_r
                                       : cur_r + ADDR_W'(1);
                            default: ;
                        endcase
                        st_r <= (fn_r == exer_pkg::FN_NONE || stop_hit)
                              ? exer_pkg::ST_IDLE : exer_pkg::ST_ISSUE;
                    end
                end
                default: st_r <= exer_pkg::ST_IDLE;
            endcase
        end
    end

    // run / pause / single step
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            paused_r   <= 1'b1;
            stepping_r <= 1'b0;
            cs_ip_r    <= '0;
            group_r    <= '0;
            cpu_run    <= 1'b0;
        end else if (clk_en) begin
            if (step_wr && !paused_r) begin
                paused_r <= 1'b1;
                cpu_run  <= 1'b0;
                cs_ip_r  <= tgt_cs_ip;
                group_r  <= evt_group;
            end else if (step_wr && paused_r && fn_r == exer_pkg::FN_NONE) begin
                stepping_r <= 1'b1;
                cpu_run    <= 1'b1;
            end else if (stepping_r && tgt_instr_done) begin
                stepping_r <= 1'b0;
                cpu_run    <= 1'b0;
                cs_ip_r    <= tgt_cs_ip;
            end else if (ctrl_wr && avs_writedata[13] && paused_r
                         && fn_r == exer_pkg::FN_NONE) begin
                paused_r <= 1'b0;
                cpu_run  <= 1'b1;
            end
        end
    end

    // interrupt gating while stepping; flag follows the switch on resume
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_accept <= 1'b0;
            irq_flag   <= 1'b0;
        end else if (clk_en) begin
            irq_accept <= tgt_irq && (!paused_r || (stepping_r && sti_r));
            if (ctrl_wr && avs_writedata[13] && paused_r)
                irq_flag <= sti_r;
        end
    end

    // trace capture gates acquisition and the event monitor
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            trace_acquire <= exer_pkg::CTRL_RST[exer_pkg::CTL_TCE];
            evt_enable    <= exer_pkg::CTRL_RST[exer_pkg::CTL_TCE];
            evt_action    <= 1'b0;
        end else if (clk_en) begin
            trace_acquire <= tce_r;
            evt_enable    <= tce_r;
            evt_action    <= tce_r && evt_hit && !paused_r;
        end
    end
endmodule : bus_exerciser
`default_nettype wire

// >>> hw/exer_pkg.sv
// constants and types for the target bus exerciser and step/trace control
package exer_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    // register byte offsets on the avalon slave
    localparam logic [3:0] OFS_CTRL  = 4'h0;
    localparam logic [3:0] OFS_ADDR  = 4'h4;
    localparam logic [3:0] OFS_LAST  = 4'h8;
    localparam logic [3:0] OFS_DATA  = 4'hc;
    localparam logic [3:0] OFS_CMD   = 4'h0; // unused alias guard
    localparam logic [3:0] OFS_GO    = 4'h1;
    // word indexes (byte offset / 4)
    localparam logic [1:0] IDX_CTRL = 2'h0;
    localparam logic [1:0] IDX_ADDR = 2'h1;
    localparam logic [1:0] IDX_LAST = 2'h2;
    localparam logic [1:0] IDX_DATA = 2'h3;
    localparam logic [1:0] IDX_STAT = 2'h0;
    // ctrl register fields
    localparam int CTL_STI   = 0;
    localparam int CTL_TCE   = 1;
    localparam int CTL_BYTE  = 2;
    localparam int CTL_IO    = 3;
    localparam int CTL_FN_LO = 4;
    localparam int CTL_SS_LO = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0002;
    localparam logic [2:0]  MSS_RST  = 3'h0;
    localparam logic [2:0]  IOS_STATUS = 3'h7;
    localparam logic [7:0]  RESET_CHAR_RST = 8'h1a;
    typedef enum logic [2:0] {
        FN_NONE   = 3'b000,
        FN_ROTATE = 3'b001,
        FN_WRRD   = 3'b010,
        FN_INCR   = 3'b011,
        FN_RANGE  = 3'b100
    } fn_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT  = 2'b10
    } bus_st_t;
endpackage : exer_pkg

// >>> tb/target_bus_model.sv
// behavioural target bus: memory and i/o answering exerciser cycles
`timescale 1ns/10ps
`default_nettype none
module target_bus_model (
    // clock, reset and answer speed (1 adds three wait cycles)
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        slow,
    // exerciser bus
    input  wire logic        tgt_req,
    input  wire logic        tgt_wr,
    input  wire logic [19:0] tgt_addr,
    input  wire logic [15:0] tgt_wdata,
    output logic             tgt_ack,
    output logic      [15:0] tgt_rdata
);
    logic [15:0] mem_r [16];
    logic [1:0]  wait_r;
    wire logic   due = tgt_req && !tgt_ack && wait_r >= (slow ? 2'h3 : 2'h0);
    // memory and i/o share one small array, low address bits only
    always_ff @(posedge clk_sys) begin
        if (reset || !tgt_req || tgt_ack) wait_r <= 2'h0;
        else if (!due) wait_r <= wait_r + 2'h1;
        tgt_ack <= !reset && due;
        if (tgt_ack && tgt_wr) mem_r[tgt_addr[3:0]] <= tgt_wdata;
        // read bus toggles outside the answer cycle so stale data never matches
        if (reset) tgt_rdata <= 16'h5a5a;
        else tgt_rdata <= (due && !tgt_wr) ? mem_r[tgt_addr[3:0]] : ~tgt_rdata;
    end
endmodule : target_bus_model
`default_nettype wire

// >>> tb/bus_exerciser_checker.sv
// port-level assertions for the target bus exerciser
`timescale 1ns/10ps
`default_nettype none
module bus_exerciser_checker #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 16
) (
    // clock, reset, register bus and operator channel
    input wire logic              clk_sys,
    input wire logic              reset,
    input wire logic [3:0]        avs_address,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic              avs_waitrequest,
    input wire logic              op_char_valid,
    // target bus, run control and event monitor
    input wire logic              tgt_req,
    input wire logic              tgt_wr,
    input wire logic              tgt_io,
    input wire logic [2:0]        tgt_status,
    input wire logic [ADDR_W-1:0] tgt_addr,
    input wire logic [DATA_W-1:0] tgt_wdata,
    input wire logic              tgt_byte,
    input wire logic              tgt_ack,
    input wire logic              cpu_run,
    input wire logic              evt_enable,
    input wire logic              evt_action
);
    logic [2:0]        fn_r;
    logic [2:0]        mss_r;
    logic [ADDR_W-1:0] lo_r;
    logic [ADDR_W-1:0] hi_r;
    logic [ADDR_W-1:0] pa_r;
    logic [DATA_W-1:0] pd_r;
    logic              stop_r;
    wire logic         wacc = avs_write && !avs_waitrequest && !cpu_run;
    wire logic [1:0]   widx = avs_address[3:2];
    always_ff @(posedge clk_sys) begin
        if (wacc && widx == 2'h0) fn_r <= avs_writedata[6:4];
        if (wacc && widx == 2'h0) mss_r <= avs_writedata[10:8];
        if (wacc && widx == 2'h1) lo_r <= avs_writedata[ADDR_W-1:0];
        if (wacc && widx == 2'h2) hi_r <= avs_writedata[ADDR_W-1:0];
        if (tgt_req && tgt_ack) pd_r <= tgt_wdata;
        if (tgt_req && tgt_ack) pa_r <= tgt_addr;
    end
    // only the reset character ends a loop, but op_char is not visible here, so loop checks rest after any operator character until restart
    always_ff @(posedge clk_sys) begin
        if (reset || (wacc && widx == 2'h0)) stop_r <= 1'b0;
        else if (op_char_valid) stop_r <= 1'b1;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset || stop_r || op_char_valid);
    sequence ack_s; tgt_req && tgt_ack; endsequence
    sequence again_s; !tgt_req ##1 tgt_req; endsequence
    req_hold_a: assert property (tgt_req && !tgt_ack |=> tgt_req &&
        $stable(tgt_addr) && $stable(tgt_wdata)) else $error("request moved");
    mem_status_a: assert property (tgt_req && !tgt_io |->
        tgt_status == mss_r) else $error("memory status wrong");
    rot_word_a: assert property (ack_s ##0 (fn_r == 3'h1 && !tgt_byte)
        |=> again_s ##0 tgt_wdata == {pd_r[DATA_W-2:0], pd_r[DATA_W-1]})
        else $error("word rotate wrong");
    rot_byte_a: assert property (ack_s ##0 (fn_r == 3'h1 && tgt_byte)
        |=> again_s ##0 tgt_wdata[7:0] == {pd_r[6:0], pd_r[7]})
        else $error("byte rotate wrong");
    wr_rd_a: assert property (ack_s ##0 (fn_r == 3'h2 && tgt_wr)
        |=> again_s ##0 (!tgt_wr && tgt_addr == pa_r)) else $error("no read back");
    incr_step_a: assert property (ack_s ##0 fn_r == 3'h3
        |=> again_s ##0 tgt_wdata[7:0] == pd_r[7:0] + 8'h01)
        else $error("increment wrong");
    range_next_a: assert property (ack_s ##0 fn_r == 3'h4
        |=> again_s ##0 tgt_addr == (pa_r == hi_r ? lo_r : pa_r + 1'b1))
        else $error("range address wrong");
    run_quiet_a: assert property (cpu_run |-> !tgt_req)
        else $error("bus cycle while target runs");
    evt_off_a: assert property (!evt_enable [*2] |-> !evt_action)
        else $error("event action while monitor off");
endmodule : bus_exerciser_checker
bind bus_exerciser bus_exerciser_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
    u_chk (.clk_sys, .reset, .avs_address, .avs_write, .avs_writedata,
    .avs_waitrequest, .op_char_valid, .tgt_req, .tgt_wr, .tgt_io, .tgt_status,
    .tgt_addr, .tgt_wdata, .tgt_byte, .tgt_ack, .cpu_run, .evt_enable,
    .evt_action);
`default_nettype wire

// >>> tb/bus_exerciser_tb.sv
// self-checking bench for the target bus exerciser
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module bus_exerciser_tb;
    typedef struct packed {
        logic io; logic wr; logic [2:0] st; logic [19:0] ad; logic [15:0] wd;
    } cyc_t;
    localparam logic [31:0] BASE = 32'h001a_0002;
    localparam logic [31:0] STEP = 32'h0000_1000;
    localparam logic [31:0] RUN  = 32'h0000_2000;
    logic clk_sys, reset, avs_read, avs_write, avs_waitrequest, op_char_valid;
    logic tgt_req, tgt_wr, tgt_io, tgt_byte, tgt_ack, tgt_irq, tgt_instr_done;
    logic evt_hit, cpu_run, irq_accept, irq_flag, trace_acquire, slow;
    logic evt_enable, evt_action;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdat;
    logic [7:0] op_char;
    logic [2:0] tgt_status;
    logic [19:0] tgt_addr;
    logic [15:0] tgt_wdata, tgt_rdata;
    cyc_t seen[$];
    int err_total = 0;
    int tests_run = 0;
    int cyc = 0;
    bus_exerciser dut (.clk_sys, .reset, .clk_en(1'b1), .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .op_char_valid, .op_char, .tgt_req, .tgt_wr, .tgt_io, .tgt_status,
        .tgt_addr, .tgt_wdata, .tgt_byte, .tgt_ack, .tgt_rdata, .tgt_irq,
        .tgt_instr_done, .tgt_cs_ip(32'h1234_5678), .evt_group(4'h9), .evt_hit,
        .cpu_run, .irq_accept, .irq_flag, .trace_acquire, .evt_enable,
        .evt_action);
    target_bus_model bus (.clk_sys, .reset, .slow, .tgt_req, .tgt_wr, .tgt_addr,
        .tgt_wdata, .tgt_ack, .tgt_rdata);
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // records every completed target cycle; also cuts a hang short
    always @(posedge clk_sys) begin
        if (tgt_req === 1'b1 && tgt_ack === 1'b1) begin
            seen.push_back({tgt_io, tgt_wr, tgt_status, tgt_addr, tgt_wdata});
        end
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic give_verdict;
        $display("tests_run %0d err_total %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick
    task automatic av(input logic rd, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        rdat = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : av
    task automatic run_fn(input logic [31:0] c, input logic [15:0] d,
                          input logic [19:0] lo, input logic [19:0] hi, int n);
        int k;
        slow <= c[3];
        av(0, 4'h4, {12'h0, lo});
        av(0, 4'h8, {12'h0, hi});
        av(0, 4'hc, {16'h0, d});
        seen.delete();
        av(0, 4'h0, c);
        while (seen.size() < n) @(posedge clk_sys);
        op_char_valid <= 1'b1;
        @(posedge clk_sys);
        op_char_valid <= 1'b0;
        tick(20);
        k = seen.size();
        tick(20);
        `CHK(seen.size(), k)
        `CHK(tgt_req, 1'b0)
    endtask : run_fn
    task automatic t_rotate;
        logic [15:0] e;
        for (int m = 0; m < 2; m++) begin
            run_fn(BASE | 32'h0510 | (m ? 32'hc : 32'h0), 16'h5, 20'h1000, 0, 17);
            e = 16'h0005;
            for (int i = 0; i < 17; i++) begin
                `CHK(seen[i].io, m[0])
                `CHK(seen[i].st, m ? 3'h7 : 3'h5)
                if (m == 0) `CHK(seen[i].wd, e)
                else `CHK(seen[i].wd[7:0], e[7:0])
                e = m ? {e[15:8], e[6:0], e[7]} : {e[14:0], e[15]};
            end
        end
    endtask : t_rotate
    task automatic t_loops;
        for (int m = 0; m < 2; m++) begin
            run_fn(BASE | 32'h520 | 32'(m * 8), 16'hffff, 20'h100, 0, 6);
            for (int i = 0; i < 6; i++) `CHK(seen[i].wr, ~i[0])
            av(1, 4'hc, 32'h0);
            `CHK(rdat[15:0], 16'hffff)
            run_fn(BASE | 32'h530 | 32'(m * 8), 16'h0, 20'h100, 0, 5);
            for (int i = 0; i < 5; i++) `CHK(seen[i].wd[7:0], i[7:0])
            run_fn(BASE | 32'h540 | 32'(m * 8), 16'h0, 20'he, 20'h11, 9);
            for (int i = 0; i < 9; i++) `CHK(seen[i].ad, 20'he + 20'(i % 4))
            `CHK(seen[8].io, m[0])
        end
    endtask : t_loops
    task automatic t_run;
        av(0, 4'h0, BASE | RUN);
        av(0, 4'h0, BASE | 32'h10);
        av(1, 4'h0, 32'h0);
        `CHK(rdat[31], 1'b1)
        evt_hit <= 1'b1;
        av(0, 4'h0, 32'h001a_0000);
        tick(2);
        `CHK(trace_acquire, 1'b0)
        `CHK(evt_action, 1'b0)
        av(0, 4'h0, BASE);
        tick(2);
        `CHK(evt_action, 1'b1)
        evt_hit <= 1'b0;
        av(0, 4'h0, BASE | STEP);
        tick(2);
        `CHK(cpu_run, 1'b0)
        av(1, 4'h4, 32'h0);
        `CHK(rdat, 32'h1234_5678)
        av(1, 4'h0, 32'h0);
        `CHK(rdat[23:20], 4'h9)
    endtask : t_run
    // steps stay clear of any non-maskable vector fetch
    task automatic t_step;
        for (int s = 1; s >= 0; s--) begin
            av(0, 4'h0, BASE | STEP | 32'(s));
            tgt_irq <= 1'b1;
            tick(2);
            `CHK(irq_accept, s[0])
            tgt_instr_done <= 1'b1;
            @(posedge clk_sys);
            tgt_instr_done <= 1'b0;
            tick(2);
            `CHK(cpu_run, 1'b0)
            tgt_irq <= 1'b0;
            av(0, 4'h0, BASE | RUN | 32'(s));
            tick(2);
            `CHK(irq_flag, s[0])
            av(0, 4'h0, BASE | STEP | 32'(s));
        end
    endtask : t_step
    initial begin
        {avs_read, avs_write, op_char_valid, tgt_irq, slow} = 5'h0;
        {tgt_instr_done, evt_hit, reset} = 3'h1;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        op_char = 8'h1a;
        tick(6);
        reset <= 1'b0;
        av(1, 4'h0, 32'h0);
        `CHK(rdat[1:0], 2'h2)
        t_rotate();
        t_loops();
        t_run();
        t_step();
        give_verdict();
    end
endmodule : bus_exerciser_tb
`default_nettype wire
